// ### inc/fpl_consts.vh
// timing and encoding constants for the front panel lamp controller
`ifndef FPL_CONSTS_VH
`define FPL_CONSTS_VH
`define FPL_CLK_HZ 125000000
`define FPL_BLINK_SLOW_HZ 1
`define FPL_BLINK_FAST_HZ 5
`define FPL_HALF_SLOW_CYC (`FPL_CLK_HZ / (2 * `FPL_BLINK_SLOW_HZ))
`define FPL_HALF_FAST_CYC (`FPL_CLK_HZ / (2 * `FPL_BLINK_FAST_HZ))
`define FPL_SHOW_S 5
`define FPL_SHOW_CYC (`FPL_CLK_HZ * `FPL_SHOW_S)
`define FPL_STRETCH_MS 30
`define FPL_STRETCH_CYC (`FPL_CLK_HZ / 1000 * `FPL_STRETCH_MS)
`define FPL_SYS_START 2'h0
`define FPL_SYS_NORMAL 2'h1
`define FPL_SYS_ERROR 2'h2
`define FPL_COL_OFF 2'h0
`define FPL_COL_GREEN 2'h1
`define FPL_COL_ORANGE 2'h2
`define FPL_COL_RED 2'h3
`endif

// ### verilog/fpl_blink_gen.v
// free running square wave generator for lamp blinking
`timescale 1ns/1ns
module fpl_blink_gen #(
	parameter HALF_CYC = 12500000
) (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// output square wave
	output reg wave
);
	reg [31:0] cnt_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 32'h0;
			wave <= 1'b0;
		end else if (cnt_q >= HALF_CYC - 1) begin
			cnt_q <= 32'h0;
			wave <= ~wave;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end
endmodule // fpl_blink_gen

// ### verilog/fpl_act_stretch.v
// stretches short activity pulses into visible on/off flashes
`timescale 1ns/1ns
module fpl_act_stretch #(
	parameter STRETCH_CYC = 3750000
) (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// activity level or pulse in, flash out
	input wire act,
	output reg flash
);
	reg [31:0] cnt_q;
	reg pend_q;
	// each phase lasts at least STRETCH_CYC so bursts read as flicker
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 32'h0;
			flash <= 1'b0;
			pend_q <= 1'b0;
		end else if (cnt_q != 32'h0) begin
			cnt_q <= cnt_q - 32'h1;
			if (act)
				pend_q <= 1'b1;
		end else if (flash) begin
			flash <= 1'b0;
			cnt_q <= STRETCH_CYC;
		end else if (act || pend_q) begin
			flash <= 1'b1;
			pend_q <= 1'b0;
			cnt_q <= STRETCH_CYC;
		end
	end
endmodule // fpl_act_stretch

// ### verilog/fpl_panel.v
// front panel lamp controller: port lamps and system lamps
// Notes on behaviour
// - enabled port without link: both lamps dark
// - linked port with traffic: green flashes with activity
// - linked port, no traffic: green steady
// - collision on half duplex linked port: orange flashes, green stays lit
// - management disabled or port not enabled: orange only; fault: both steady
// - condition lamp red during start-up, steady green once started
// - failed start-up leaves condition lamp red
// - software update or recovery: condition lamp blinks green 1 Hz
// - maintenance mode: condition lamp blinks green 5 Hz
// - reset or detected error: condition lamp red
// - thermal lamp green when normal, orange when warm
// - over-temperature: thermal lamp red and shutdown requested
// - backup supply lamp off if absent, green if present but idle
// - backup supply carrying load: lamp orange
// - button press shows speed and duplex for five seconds
// - during display: green is 100Mbps, orange is full duplex
`timescale 1ns/1ns
`include "fpl_consts.vh"
module fpl_panel #(
	parameter PORTS = 8,
	parameter SHOW_CYC = `FPL_SHOW_CYC,
	parameter HALF_SLOW_CYC = `FPL_HALF_SLOW_CYC,
	parameter HALF_FAST_CYC = `FPL_HALF_FAST_CYC,
	parameter STRETCH_CYC = `FPL_STRETCH_CYC
) (
	// clock and reset
	input wire CLOCK,
	input wire ARST_N,
	// per-port status, one bit per port
	input wire [PORTS-1:0] PORT_ENABLED,
	input wire [PORTS-1:0] PORT_MGMT_OFF,
	input wire [PORTS-1:0] PORT_FAULT,
	input wire [PORTS-1:0] PORT_LINK,
	input wire [PORTS-1:0] PORT_ACTIVITY,
	input wire [PORTS-1:0] PORT_COLLISION,
	input wire [PORTS-1:0] PORT_FULL_DUPLEX,
	input wire [PORTS-1:0] PORT_SPEED_100,
	// system status
	input wire START_DONE,
	input wire START_FAIL,
	input wire SYS_ERROR,
	input wire SW_UPDATE,
	input wire MAINT_MODE,
	input wire TEMP_WARM,
	input wire TEMP_LIMIT,
	input wire BACKUP_SUPPLY_PRESENT,
	input wire BACKUP_SUPPLY_ACTIVE,
	// push button, already debounced, level high while pressed
	input wire STATUS_BUTTON,
	// port lamps
	output reg [PORTS-1:0] PORT_GREEN,
	output reg [PORTS-1:0] PORT_ORANGE,
	// system lamps, two-bit colour codes
	output reg [1:0] SYS_LAMP,
	output reg [1:0] TEMP_LAMP,
	output reg [1:0] BACKUP_SUPPLY_LAMP,
	// shutdown request and display mode indication
	output reg SHUTDOWN_REQ,
	output reg SHOW_ACTIVE
);
	localparam ST_START = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_FAIL = 2'h2;

	wire slow_wave;
	wire fast_wave;
	wire [PORTS-1:0] act_flash;
	wire [PORTS-1:0] col_flash;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg btn_q;
	reg [31:0] show_q;
	reg [PORTS-1:0] green_d;
	reg [PORTS-1:0] orange_d;
	reg [1:0] sys_d;
	reg [1:0] temp_d;
	reg [1:0] bsup_d;
	integer i;

	fpl_blink_gen #(
		.HALF_CYC(HALF_SLOW_CYC)
	) u_slow (
		.clk(CLOCK),
		.arst_n(ARST_N),
		.wave(slow_wave)
	);

	fpl_blink_gen #(
		.HALF_CYC(HALF_FAST_CYC)
	) u_fast (
		.clk(CLOCK),
		.arst_n(ARST_N),
		.wave(fast_wave)
	);

	genvar g;
	generate
		for (g = 0; g < PORTS; g = g + 1) begin : g_port
			fpl_act_stretch #(
				.STRETCH_CYC(STRETCH_CYC)
			) u_act (
				.clk(CLOCK),
				.arst_n(ARST_N),
				.act(PORT_ACTIVITY[g]),
				.flash(act_flash[g])
			);
			fpl_act_stretch #(
				.STRETCH_CYC(STRETCH_CYC)
			) u_col (
				.clk(CLOCK),
				.arst_n(ARST_N),
				.act(PORT_COLLISION[g] & ~PORT_FULL_DUPLEX[g]),
				.flash(col_flash[g])
			);
		end
	endgenerate

	// start-up sequence
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_START: begin
				if (START_FAIL)
					state_d = ST_FAIL;
				else if (START_DONE)
					state_d = ST_RUN;
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_FAIL;
			end
		endcase
	end

	// five second display timer, restarted on each press
	always @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= ST_START;
			btn_q <= 1'b0;
			show_q <= 32'h0;
		end else begin
			state_q <= state_d;
			btn_q <= STATUS_BUTTON;
			if (STATUS_BUTTON && !btn_q)
				show_q <= SHOW_CYC;
			else if (show_q != 32'h0)
				show_q <= show_q - 32'h1;
		end
	end

	// port lamp decode
	always @* begin
		green_d = {PORTS{1'b0}};
		orange_d = {PORTS{1'b0}};
		for (i = 0; i < PORTS; i = i + 1) begin
			if (show_q != 32'h0) begin
				green_d[i] = PORT_SPEED_100[i];
				orange_d[i] = PORT_FULL_DUPLEX[i];
			end else if (PORT_FAULT[i]) begin
				green_d[i] = 1'b1;
				orange_d[i] = 1'b1;
			end else if (PORT_MGMT_OFF[i] || !PORT_ENABLED[i]) begin
				orange_d[i] = 1'b1;
			end else if (!PORT_LINK[i]) begin
				green_d[i] = 1'b0;
			end else if (col_flash[i]) begin
				green_d[i] = 1'b1;
				orange_d[i] = 1'b1;
			end else begin
				green_d[i] = ~act_flash[i];
			end
		end
	end

	// system lamp decode
	always @* begin
		sys_d = `FPL_COL_RED;
		if (SYS_ERROR || state_q != ST_RUN)
			sys_d = `FPL_COL_RED;
		else if (MAINT_MODE)
			sys_d = fast_wave ? `FPL_COL_GREEN : `FPL_COL_OFF;
		else if (SW_UPDATE)
			sys_d = slow_wave ? `FPL_COL_GREEN : `FPL_COL_OFF;
		else
			sys_d = `FPL_COL_GREEN;
		if (TEMP_LIMIT)
			temp_d = `FPL_COL_RED;
		else if (TEMP_WARM)
			temp_d = `FPL_COL_ORANGE;
		else
			temp_d = `FPL_COL_GREEN;
		if (BACKUP_SUPPLY_ACTIVE)
			bsup_d = `FPL_COL_ORANGE;
		else if (BACKUP_SUPPLY_PRESENT)
			bsup_d = `FPL_COL_GREEN;
		else
			bsup_d = `FPL_COL_OFF;
	end

	// registered lamp outputs; red on the condition lamp during reset
	always @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			PORT_GREEN <= {PORTS{1'b0}};
			PORT_ORANGE <= {PORTS{1'b0}};
			SYS_LAMP <= `FPL_COL_RED;
			TEMP_LAMP <= `FPL_COL_OFF;
			BACKUP_SUPPLY_LAMP <= `FPL_COL_OFF;
			SHUTDOWN_REQ <= 1'b0;
			SHOW_ACTIVE <= 1'b0;
		end else begin
			PORT_GREEN <= green_d;
			PORT_ORANGE <= orange_d;
			SYS_LAMP <= sys_d;
			TEMP_LAMP <= temp_d;
			BACKUP_SUPPLY_LAMP <= bsup_d;
			SHUTDOWN_REQ <= TEMP_LIMIT;
			SHOW_ACTIVE <= (show_q != 32'h0);
		end
	end
endmodule // fpl_panel

// ### dv/fpl_front.sv
// far-side model: the push button of the front panel
`timescale 1ns/1ns
module fpl_front (
	// clock
	input wire clk,
	// request from the bench, button level out
	input wire press,
	output reg button
);
	reg [1:0] hold_q;
	initial begin
		button = 1'b0;
		hold_q = 2'h0;
	end
	// a finger keeps the contact closed for several cycles
	always @(posedge clk) begin
		if (press)
			hold_q <= 2'h3;
		else if (hold_q != 2'h0)
			hold_q <= hold_q - 2'h1;
		button <= press || hold_q != 2'h0;
	end
endmodule // fpl_front

// ### dv/fpl_panel_chk.sv
// port and system lamp assertions for the lamp controller
`timescale 1ns/1ns
module fpl_chk #(
	parameter PORTS = 8
) (
	// clock and reset
	input wire CLOCK,
	input wire ARST_N,
	// inputs watched
	input wire [PORTS-1:0] PORT_ENABLED,
	input wire [PORTS-1:0] PORT_MGMT_OFF,
	input wire [PORTS-1:0] PORT_FAULT,
	input wire [PORTS-1:0] PORT_LINK,
	input wire SYS_ERROR,
	input wire TEMP_LIMIT,
	input wire BACKUP_SUPPLY_ACTIVE,
	input wire STATUS_BUTTON,
	// outputs watched
	input wire [PORTS-1:0] PORT_GREEN,
	input wire [PORTS-1:0] PORT_ORANGE,
	input wire [1:0] SYS_LAMP,
	input wire [1:0] TEMP_LAMP,
	input wire [1:0] BACKUP_SUPPLY_LAMP,
	input wire SHUTDOWN_REQ,
	input wire SHOW_ACTIVE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	shut_req_a: assert property (SHUTDOWN_REQ == $past(TEMP_LIMIT))
		else $error("shutdown request not one cycle after limit");
	temp_red_a: assert property (TEMP_LIMIT |=> TEMP_LAMP == 2'h3)
		else $error("thermal lamp not red at limit");
	sys_red_a: assert property (SYS_ERROR |=> SYS_LAMP == 2'h3)
		else $error("condition lamp not red on error");
	backup_on_a: assert property (BACKUP_SUPPLY_ACTIVE |=>
		BACKUP_SUPPLY_LAMP == 2'h2)
		else $error("backup lamp not orange under load");
	show_start_a: assert property ($rose(STATUS_BUTTON) |->
		##2 SHOW_ACTIVE)
		else $error("display not started two cycles after press");
	port_fault_a: assert property (PORT_FAULT[0] ##1 !SHOW_ACTIVE |->
		PORT_GREEN[0] && PORT_ORANGE[0])
		else $error("faulty port not showing both lamps");
	port_mgmt_a: assert property (PORT_MGMT_OFF[0] && !PORT_FAULT[0]
		##1 !SHOW_ACTIVE |-> !PORT_GREEN[0] && PORT_ORANGE[0])
		else $error("disabled port not orange only");
	port_dark_a: assert property (PORT_ENABLED[0] && !PORT_LINK[0]
		&& !PORT_FAULT[0] && !PORT_MGMT_OFF[0] ##1 !SHOW_ACTIVE
		|-> !PORT_GREEN[0] && !PORT_ORANGE[0])
		else $error("unlinked port not dark");
endmodule // fpl_chk
bind fpl_panel fpl_chk #(.PORTS(PORTS)) chk_u (.*);

// ### dv/testbench.sv
// self-checking bench for the lamp controller
`timescale 1ns/1ns
module testbench;
	reg CLOCK;
	reg ARST_N;
	reg press;
	reg [15:0] pi;
	reg [9:0] si;
	wire btn;
	wire [1:0] pg;
	wire [1:0] po;
	wire [1:0] sl;
	wire [1:0] tl;
	wire [1:0] bl;
	wire sr;
	wire sa;
	integer err_total = 0;
	integer samples_checked = 0;
	integer cyc_n = 0;
	integer n;
	integer m;
	fpl_front front_u (.clk(CLOCK), .press(press), .button(btn));
	fpl_panel #(.PORTS(2), .SHOW_CYC(200), .HALF_SLOW_CYC(20),
		.HALF_FAST_CYC(4), .STRETCH_CYC(3)) dut_u (
		.CLOCK(CLOCK), .ARST_N(ARST_N),
		.PORT_ENABLED(pi[1:0]), .PORT_MGMT_OFF(pi[3:2]),
		.PORT_FAULT(pi[5:4]), .PORT_LINK(pi[7:6]),
		.PORT_ACTIVITY(pi[9:8]), .PORT_COLLISION(pi[11:10]),
		.PORT_FULL_DUPLEX(pi[13:12]), .PORT_SPEED_100(pi[15:14]),
		.START_DONE(si[0]), .START_FAIL(si[1]), .SYS_ERROR(si[2]),
		.SW_UPDATE(si[3]), .MAINT_MODE(si[4]), .TEMP_WARM(si[5]),
		.TEMP_LIMIT(si[6]), .BACKUP_SUPPLY_PRESENT(si[7]),
		.BACKUP_SUPPLY_ACTIVE(si[8]), .STATUS_BUTTON(btn),
		.PORT_GREEN(pg), .PORT_ORANGE(po), .SYS_LAMP(sl),
		.TEMP_LAMP(tl), .BACKUP_SUPPLY_LAMP(bl),
		.SHUTDOWN_REQ(sr), .SHOW_ACTIVE(sa));
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	task chk(input [15:0] g, input [15:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("[FAIL] %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task cyc(input integer k);
		begin
			repeat (k) @(posedge CLOCK);
			#1;
		end
	endtask
	task drv(input [15:0] p, input [9:0] s);
		begin
			@(posedge CLOCK);
			pi <= p;
			si <= s;
			cyc(3);
		end
	endtask
	task rst;
		begin
			@(posedge CLOCK);
			ARST_N <= 1'b0;
			cyc(8);
			chk(sl, 2'h3);
			@(posedge CLOCK);
			ARST_N <= 1'b1;
			cyc(0);
		end
	endtask
	task t_start;
		begin
			drv(16'h0000, 10'h002);
			drv(16'h0000, 10'h001);
			chk(sl, 2'h3);
			rst;
			chk(sl, 2'h3);
			drv(16'h0000, 10'h001);
			chk(sl, 2'h1);
			drv(16'h0000, 10'h005);
			chk(sl, 2'h3);
		end
	endtask
	// blinks are judged on green share and toggle rate over whole periods
	task blink(input [9:0] s, input [15:0] fast);
		reg [1:0] p;
		begin
			drv(16'h0000, s);
			n = 0;
			m = 0;
			p = sl;
			repeat (840) begin
				cyc(1);
				n = n + (sl === 2'h1);
				m = m + (sl !== p);
				p = sl;
			end
			chk(n, 420);
			chk(m > 50, fast);
		end
	endtask
	task t_env;
		begin
			drv(16'h0000, 10'h001);
			chk({sr, tl, bl}, 5'h04);
			drv(16'h0000, 10'h0A1);
			chk({sr, tl, bl}, 5'h09);
			drv(16'h0000, 10'h1C1);
			chk({sr, tl, bl}, 5'h1E);
		end
	endtask
	task t_ports;
		begin
			drv(16'h0043, 10'h001);
			chk({po, pg}, 4'h1);
			drv(16'h00E7, 10'h001);
			chk({po, pg}, 4'hE);
		end
	endtask
	// one-cycle pulses must stretch into a visible flash
	task act(input [15:0] p, input [15:0] eg, input [15:0] eo);
		begin
			drv(16'h30C3 & p, 10'h001);
			@(posedge CLOCK);
			pi <= p;
			@(posedge CLOCK);
			pi <= 16'h30C3 & p;
			n = 0;
			m = 0;
			repeat (20) begin
				#1;
				n = n + (pg[0] === 1'b0);
				m = m + (po[1] === 1'b1);
				@(posedge CLOCK);
			end
			chk(n, eg);
			chk(m != 0, eo);
		end
	endtask
	task t_show;
		begin
			drv(16'h60C3, 10'h001);
			@(posedge CLOCK);
			press <= 1'b1;
			@(posedge CLOCK);
			press <= 1'b0;
			n = 0;
			while (sa !== 1'b1 && n < 10) begin
				cyc(1);
				n = n + 1;
			end
			chk({po, pg}, 4'h9);
			n = 0;
			while (sa === 1'b1 && n < 300) begin
				cyc(1);
				n = n + 1;
			end
			chk(n >= 199 && n <= 201, 1);
			cyc(2);
			chk({po, pg}, 4'h3);
		end
	endtask
	task end_of_test;
		begin
			$display("errors %0d checks %0d", err_total, samples_checked);
			if (err_total == 0 && samples_checked > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	always @(posedge CLOCK) begin
		cyc_n = cyc_n + 1;
		if (cyc_n == 6000) begin
			err_total = err_total + 1;
			end_of_test;
		end
	end
	initial begin
		ARST_N = 1'b0;
		press = 1'b0;
		pi = 16'h0000;
		si = 10'h000;
		rst;
		t_start;
		blink(10'h011, 1);
		blink(10'h009, 0);
		t_env;
		t_ports;
		act(16'h01C3, 4, 0);
		act(16'h08C3, 0, 1);
		act(16'h28C3, 0, 0);
		t_show;
		end_of_test;
	end
endmodule // testbench
